// ===== gpio_cfg_pkg.sv
/*
 * Constants for the pin function block: line counts, mode codes,
 * register offsets, field layouts and timing counts.
 * Assumes a 40 MHz system clock.
 */
`default_nettype none
package gpio_cfg_pkg;
   localparam int NUM_LINES = 13;
   localparam int MODE_W    = 3;

   // Mode codes
   typedef enum logic [2:0] {
      MODE_IN_QUIET = 3'b000,
      MODE_IN_MON   = 3'b001,
      MODE_OUT_LOW  = 3'b010,
      MODE_OUT_HIGH = 3'b011,
      MODE_ANALOG   = 3'b100,
      MODE_ALT      = 3'b101
   } mode_t;

   // Special lines
   localparam int LINE_JOIN  = 0;
   localparam int LINE_PWR   = 1;
   localparam int LINE_LINK  = 2;
   localparam int LINE_AI_LO = 3;
   localparam int LINE_AI_HI = 6;
   localparam int LINE_CTS   = 8;
   localparam int LINE_RTS   = 9;
   localparam int LINE_DTR   = 10;
   localparam int LINE_DSR   = 11;

   // Register byte addresses
   localparam logic [11:0] OFS_MODE_ALL  = 12'h000;
   localparam logic [11:0] OFS_MODE_ONE  = 12'h004;
   localparam logic [11:0] OFS_OUT       = 12'h008;
   localparam logic [11:0] OFS_IN        = 12'h00C;
   localparam logic [11:0] OFS_NODE      = 12'h010;
   localparam logic [11:0] OFS_JOIN_TIME = 12'h014;
   localparam logic [11:0] OFS_STATUS    = 12'h018;
   localparam logic [11:0] OFS_UART      = 12'h01C;

   // Field positions
   localparam int ONE_SEL_LSB  = 4;
   localparam int ONE_SEL_W    = 4;
   localparam int NODE_W       = 2;
   localparam int ST_FDR       = 0;
   localparam int ST_BOOT      = 1;
   localparam int ST_WAKE      = 2;
   localparam int ST_JOINED    = 3;
   localparam int ST_JOIN_OPEN = 4;

   // Node types
   localparam logic [1:0] NODE_COORD  = 2'h0;
   localparam logic [1:0] NODE_ROUTER = 2'h1;
   localparam logic [1:0] NODE_END    = 2'h2;
   localparam logic [1:0] NODE_SLEEPY = 2'h3;

   // Reset values
   localparam logic [31:0] JOIN_TIME_RST = 32'h0000_00FF;

   // Timing
   localparam int CLK_HZ       = 40_000_000;
   localparam int LONG_PRESS_MS = 2000;
   localparam int LONG_PRESS_CYC = CLK_HZ / 1000 * LONG_PRESS_MS;
   localparam int DEBOUNCE_MS   = 10;
   localparam int DEBOUNCE_CYC  = CLK_HZ / 1000 * DEBOUNCE_MS;
   localparam int BLINK_MS      = 500;
   localparam int BLINK_CYC     = CLK_HZ / 1000 * BLINK_MS;
   localparam int SECOND_CYC    = CLK_HZ;
   localparam int CNT_W         = 32;
endpackage
`default_nettype wire

// ===== button_filter.sv
/*
 * Button conditioner: two-stage synchroniser, debounce, edge pulse.
 * Assumes an idle-high button that pulls low when pressed.
 */
`default_nettype none
module button_filter
   import gpio_cfg_pkg::*;
#(
   parameter int DEBOUNCE = DEBOUNCE_CYC
) (
   // Clock and reset
   input  wire logic clk,
   input  wire logic nrst,
   // Pin
   input  wire logic pin,
   // Filtered
   output logic      level,
   output logic      fall
);
   logic            sync_a;
   logic            sync_b;
   logic [CNT_W-1:0] stable_cnt;

   // ----------------------------------------
   // Synchroniser
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (!nrst) begin
         sync_a <= 1'b1;
         sync_b <= 1'b1;
      end else begin
         sync_a <= pin;
         sync_b <= sync_a;
      end
   end

   // ----------------------------------------
   // Debounce
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (!nrst) begin
         stable_cnt <= '0;
         level      <= 1'b1;
         fall       <= 1'b0;
      end else begin
         fall <= 1'b0;
         if (sync_b == level) begin
            stable_cnt <= '0;
         end else if (stable_cnt == CNT_W'(DEBOUNCE - 1)) begin
            stable_cnt <= '0;
            level      <= sync_b;
            fall       <= ~sync_b;
         end else begin
            stable_cnt <= stable_cnt + 1'b1;
         end
      end
   end
endmodule // button_filter
`default_nettype wire

// ===== gpio_pin_function.sv
/*
 * Pin function selection for thirteen general lines and a dedicated
 * factory-reset button, with an APB register slave.
 * Assumes one 40 MHz clock; pins are asynchronous to it.
 */
`default_nettype none
module gpio_pin_function
   import gpio_cfg_pkg::*;
#(
   parameter int LONG_PRESS = LONG_PRESS_CYC,
   parameter int DEBOUNCE   = DEBOUNCE_CYC,
   parameter int BLINK      = BLINK_CYC,
   parameter int SECOND     = SECOND_CYC
) (
   // Clock and reset
   input  wire logic                 clk,
   input  wire logic                 nrst,
   // APB slave
   input  wire logic                 psel,
   input  wire logic                 penable,
   input  wire logic                 pwrite,
   input  wire logic [11:0]          paddr,
   input  wire logic [31:0]          pwdata,
   output logic      [31:0]          prdata,
   output logic                      pready,
   output logic                      pslverr,
   // General lines
   input  wire logic [NUM_LINES-1:0] line_in,
   output logic      [NUM_LINES-1:0] line_out,
   output logic      [NUM_LINES-1:0] line_oe_n,
   output logic      [3:0]           analog_enable,
   // Factory reset button
   input  wire logic                 factory_reset_button,
   // Firmware events
   output logic                      factory_restore,
   output logic                      boot_menu,
   output logic                      wake_req,
   output logic                      join_open,
   // UART handshake
   input  wire logic                 uart_rts,
   input  wire logic                 uart_dtr,
   output logic                      uart_cts,
   output logic                      uart_dsr
);
   mode_t              mode [NUM_LINES];
   logic [NUM_LINES-1:0] out_val;
   logic [NUM_LINES-1:0] in_sync_a;
   logic [NUM_LINES-1:0] in_sync_b;
   logic [NODE_W-1:0]  node_type;
   logic [31:0]        join_time;
   logic               joined;
   logic               fdr_level;
   logic               fdr_fall;
   logic               join_level;
   logic               join_fall;
   logic               join_raw;
   logic               armed;
   logic               qualified;
   logic [CNT_W-1:0]   press_cnt;
   logic [CNT_W-1:0]   sec_cnt;
   logic [31:0]        join_left;
   logic [CNT_W-1:0]   blink_cnt;
   logic               blink;
   logic               boot_done;
   logic               wr_en;
   logic               rd_en;
   logic               addr_ok;
   logic               wake_flag;
   logic [ONE_SEL_W-1:0] one_sel;
   mode_t              one_mode;

   // ----------------------------------------
   // Bus decode
   // ----------------------------------------
   assign pready  = 1'b1;
   assign wr_en   = psel & penable & pwrite;
   assign rd_en   = psel & penable & ~pwrite;
   assign one_sel = pwdata[ONE_SEL_LSB +: ONE_SEL_W];
   assign one_mode = mode_t'(pwdata[MODE_W-1:0]);

   always_comb begin
      unique case (paddr)
         OFS_MODE_ALL, OFS_MODE_ONE, OFS_OUT, OFS_IN,
         OFS_NODE, OFS_JOIN_TIME, OFS_STATUS, OFS_UART: addr_ok = 1'b1;
         default: addr_ok = 1'b0;
      endcase
   end
   assign pslverr = psel & penable & ~addr_ok;

   function automatic logic mode_legal(input int line, input mode_t m);
      logic ok;
      ok = (m <= MODE_ALT);
      if (m == MODE_ANALOG && (line < LINE_AI_LO || line > LINE_AI_HI))
         ok = 1'b0;
      return ok;
   endfunction

   // ----------------------------------------
   // Mode registers
   // ----------------------------------------
   generate
      for (genvar i = 0; i < NUM_LINES; i++) begin : g_mode
         always_ff @(posedge clk) begin
            if (!nrst) begin
               mode[i] <= MODE_IN_QUIET;
            end else if (wr_en && paddr == OFS_MODE_ALL) begin
               // One code for all lines; 13 fields overflow the word
               if (mode_legal(i, one_mode))
                  mode[i] <= one_mode;
            end else if (wr_en && paddr == OFS_MODE_ONE &&
                         one_sel == ONE_SEL_W'(i)) begin
               if (mode_legal(i, one_mode))
                  mode[i] <= one_mode;
            end
         end
      end
   endgenerate

   // ----------------------------------------
   // Output values and settings
   // ----------------------------------------
   generate
      for (genvar i = 0; i < NUM_LINES; i++) begin : g_out
         always_ff @(posedge clk) begin
            if (!nrst) begin
               out_val[i] <= 1'b0;
            end else if (wr_en && paddr == OFS_OUT) begin
               out_val[i] <= pwdata[i];
            end else if (wr_en && paddr == OFS_MODE_ALL &&
                         one_mode == MODE_OUT_HIGH)
            begin
               out_val[i] <= 1'b1;
            end else if (wr_en && paddr == OFS_MODE_ALL &&
                         one_mode == MODE_OUT_LOW)
            begin
               out_val[i] <= 1'b0;
            end else if (wr_en && paddr == OFS_MODE_ONE &&
                         one_sel == ONE_SEL_W'(i) &&
                         (one_mode == MODE_OUT_HIGH ||
                          one_mode == MODE_OUT_LOW)) begin
               out_val[i] <= (one_mode == MODE_OUT_HIGH);
            end
         end
      end
   endgenerate

   always_ff @(posedge clk) begin
      if (!nrst) begin
         node_type <= NODE_COORD;
         join_time <= JOIN_TIME_RST;
         joined    <= 1'b0;
      end else if (wr_en && paddr == OFS_NODE) begin
         node_type <= pwdata[NODE_W-1:0];
         joined    <= pwdata[NODE_W];
      end else if (wr_en && paddr == OFS_JOIN_TIME) begin
         join_time <= pwdata;
      end
   end

   // ----------------------------------------
   // Input synchroniser
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (!nrst) begin
         in_sync_a <= '0;
         in_sync_b <= '0;
      end else begin
         in_sync_a <= line_in;
         in_sync_b <= in_sync_a;
      end
   end

   // ----------------------------------------
   // Buttons
   // ----------------------------------------
   button_filter #(.DEBOUNCE(DEBOUNCE)) u_fdr (
      .clk   (clk),
      .nrst  (nrst),
      .pin   (factory_reset_button),
      .level (fdr_level),
      .fall  (fdr_fall)
   );

   assign join_raw = line_in[LINE_JOIN] | (mode[LINE_JOIN] != MODE_ALT);

   button_filter #(.DEBOUNCE(DEBOUNCE)) u_join (
      .clk   (clk),
      .nrst  (nrst),
      .pin   (join_raw),
      .level (join_level),
      .fall  (join_fall)
   );

   // ----------------------------------------
   // Factory reset and boot menu
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (!nrst) begin
         armed           <= 1'b0;
         qualified       <= 1'b0;
         press_cnt       <= '0;
         factory_restore <= 1'b0;
      end else begin
         factory_restore <= 1'b0;
         if (fdr_fall && boot_done) begin
            armed     <= 1'b1;
            qualified <= 1'b0;
            press_cnt <= '0;
         end else if (armed && !fdr_level) begin
            if (press_cnt >= CNT_W'(LONG_PRESS))
               qualified <= 1'b1;
            else
               press_cnt <= press_cnt + 1'b1;
         end else if (armed && fdr_level) begin
            armed           <= 1'b0;
            factory_restore <= qualified;
            qualified       <= 1'b0;
         end
      end
   end

   // Startup level caught once after the filter settles
   always_ff @(posedge clk) begin
      if (!nrst) begin
         boot_done <= 1'b0;
         boot_menu <= 1'b0;
         sec_cnt   <= '0;
      end else if (!boot_done) begin
         if (sec_cnt == CNT_W'(DEBOUNCE + 4)) begin
            boot_done <= 1'b1;
            boot_menu <= ~fdr_level;
         end else begin
            sec_cnt <= sec_cnt + 1'b1;
         end
      end
   end

   // ----------------------------------------
   // Join window and wake
   // ----------------------------------------
   logic [CNT_W-1:0] tick_cnt;
   always_ff @(posedge clk) begin
      if (!nrst) begin
         join_left <= '0;
         tick_cnt  <= '0;
         wake_req  <= 1'b0;
         wake_flag <= 1'b0;
      end else begin
         wake_req <= 1'b0;
         if (join_fall && mode[LINE_JOIN] == MODE_ALT &&
             (node_type == NODE_COORD || node_type == NODE_ROUTER)) begin
            join_left <= join_time;
            tick_cnt  <= '0;
         end else if (join_left != '0) begin
            if (tick_cnt == CNT_W'(SECOND - 1)) begin
               tick_cnt  <= '0;
               join_left <= join_left - 1'b1;
            end else begin
               tick_cnt <= tick_cnt + 1'b1;
            end
         end
         if (join_fall && mode[LINE_JOIN] == MODE_ALT &&
             node_type == NODE_SLEEPY) begin
            wake_req  <= 1'b1;
            wake_flag <= 1'b1;
         end else if (rd_en && paddr == OFS_STATUS) begin
            wake_flag <= 1'b0;
         end
      end
   end
   assign join_open = (join_left != '0);

   // ----------------------------------------
   // Blink timer
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (!nrst) begin
         blink_cnt <= '0;
         blink     <= 1'b0;
      end else if (blink_cnt == CNT_W'(BLINK - 1)) begin
         blink_cnt <= '0;
         blink     <= ~blink;
      end else begin
         blink_cnt <= blink_cnt + 1'b1;
      end
   end

   // ----------------------------------------
   // Pin drive
   // ----------------------------------------
   generate
      for (genvar i = 0; i < NUM_LINES; i++) begin : g_pin
         always_ff @(posedge clk) begin
            if (!nrst) begin
               line_out[i]  <= 1'b0;
               line_oe_n[i] <= 1'b1;
            end else begin
               line_out[i]  <= out_val[i];
               line_oe_n[i] <= ~(mode[i] == MODE_OUT_LOW ||
                                 mode[i] == MODE_OUT_HIGH);
               if (mode[i] == MODE_ALT) begin
                  line_oe_n[i] <= 1'b1;
                  if (i == LINE_PWR) begin
                     line_oe_n[i] <= 1'b0;
                     line_out[i]  <= (node_type == NODE_END ||
                                      node_type == NODE_SLEEPY) ?
                                     blink : 1'b1;
                  end
                  if (i == LINE_LINK) begin
                     line_oe_n[i] <= 1'b0;
                     line_out[i]  <= join_open ? blink : joined;
                  end
                  if (i == LINE_RTS) begin
                     line_oe_n[i] <= 1'b0;
                     line_out[i]  <= uart_rts;
                  end
                  if (i == LINE_DTR) begin
                     line_oe_n[i] <= 1'b0;
                     line_out[i]  <= uart_dtr;
                  end
               end
            end
         end
      end
   endgenerate

   generate
      for (genvar c = 0; c < 4; c++) begin : g_ai
         assign analog_enable[c] =
            (mode[LINE_AI_LO + c] == MODE_ANALOG);
      end
   endgenerate

   always_ff @(posedge clk) begin
      if (!nrst) begin
         uart_cts <= 1'b0;
         uart_dsr <= 1'b0;
      end else begin
         uart_cts <= (mode[LINE_CTS] == MODE_ALT) & in_sync_b[LINE_CTS];
         uart_dsr <= (mode[LINE_DSR] == MODE_ALT) & in_sync_b[LINE_DSR];
      end
   end

   // ----------------------------------------
   // Read data
   // ----------------------------------------
   always_comb begin
      prdata = '0;
      unique case (paddr)
         OFS_MODE_ALL: begin
            // Only the lines whose field fits the word
            for (int i = 0; i < $bits(prdata) / MODE_W; i++)
               prdata[i*MODE_W +: MODE_W] = mode[i];
         end
         OFS_OUT:       prdata[NUM_LINES-1:0] = out_val;
         OFS_IN:        prdata[NUM_LINES-1:0] = in_sync_b;
         OFS_NODE:      prdata[NODE_W:0] = {joined, node_type};
         OFS_JOIN_TIME: prdata = join_time;
         OFS_STATUS: begin
            prdata[ST_FDR]       = armed;
            prdata[ST_BOOT]      = boot_menu;
            prdata[ST_WAKE]      = wake_flag;
            prdata[ST_JOINED]    = joined;
            prdata[ST_JOIN_OPEN] = join_open;
         end
         OFS_UART:      prdata[1:0] = {uart_dsr, uart_cts};
         default:       prdata = '0;
      endcase
   end
endmodule // gpio_pin_function
`default_nettype wire

// ===== gpio_pin_function_assertions.sv
/*
 * Port-level checks for the pin function block.
 * Assumes it is bound into gpio_pin_function and shares its LONG_PRESS parameter.
 */
`default_nettype none
module gpio_pin_function_assertions
   import gpio_cfg_pkg::*;
#(
   parameter int LONG_PRESS = LONG_PRESS_CYC
) (
   // Clock and reset
   input wire logic                 clk,
   input wire logic                 nrst,
   // Bus
   input wire logic                 psel,
   input wire logic                 penable,
   input wire logic                 pready,
   input wire logic                 pslverr,
   // Pins and events
   input wire logic [NUM_LINES-1:0] line_oe_n,
   input wire logic [3:0]           analog_enable,
   input wire logic                 factory_reset_button,
   input wire logic                 factory_restore,
   input wire logic                 boot_menu,
   input wire logic                 wake_req,
   input wire logic                 uart_cts,
   input wire logic                 uart_dsr
);
   timeunit 1ns;
   timeprecision 100ps;
   // ---------------------------------------------
   // Raw press length tracking
   // ---------------------------------------------
   logic [CNT_W-1:0] low_cnt;
   logic             long_seen;

   always_ff @(posedge clk) begin
      if (!nrst || factory_reset_button)
         low_cnt <= '0;
      else
         low_cnt <= low_cnt + 1'b1;
   end

   always_ff @(posedge clk) begin
      if (!nrst || factory_restore)
         long_seen <= 1'b0;
      else if (low_cnt >= CNT_W'(LONG_PRESS))
         long_seen <= 1'b1;
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);

   zero_wait_a: assert property (psel && penable |-> pready)
      else $error("access not answered at once");
   bus_error_a: assert property (pslverr |-> psel && penable)
      else $error("error flag outside access");
   cts_input_a: assert property (uart_cts |-> line_oe_n[LINE_CTS])
      else $error("cts seen on a driven line");
   dsr_input_a: assert property (uart_dsr |-> line_oe_n[LINE_DSR])
      else $error("dsr seen on a driven line");
   analog_float_a: assert property (
      ((analog_enable & $past(analog_enable)) & ~line_oe_n[6:3]) == 4'h0)
      else $error("analog line driven");
   restore_pulse_a: assert property (factory_restore |=> !factory_restore)
      else $error("restore pulse too long");
   wake_pulse_a: assert property (wake_req |=> !wake_req)
      else $error("wake pulse too long");
   restore_release_a: assert property (factory_restore |->
      $past(factory_reset_button, 2) && $past(factory_reset_button, 3))
      else $error("restore while button held");
   restore_long_a: assert property (factory_restore |-> long_seen)
      else $error("restore without long press");
   boot_hold_a: assert property (boot_menu |=> boot_menu)
      else $error("boot menu dropped");
endmodule // gpio_pin_function_assertions

bind gpio_pin_function gpio_pin_function_assertions #(
   .LONG_PRESS(LONG_PRESS)
) u_checks (.clk, .nrst, .psel, .penable, .pready, .pslverr, .line_oe_n,
   .analog_enable, .factory_reset_button, .factory_restore, .boot_menu,
   .wake_req, .uart_cts, .uart_dsr);
`default_nettype wire

// ===== pin_peer.sv
/*
 * Far side of the pins: buttons, indicators and a UART peer.
 * Assumes output enables are low while the block drives a line.
 */
`default_nettype none
module pin_peer
   import gpio_cfg_pkg::*;
(
   // Block side
   input  wire logic [NUM_LINES-1:0] line_out,
   input  wire logic [NUM_LINES-1:0] line_oe_n,
   output logic      [NUM_LINES-1:0] line_in,
   output logic                      factory_reset_button,
   // Peer side
   input  wire logic [NUM_LINES-1:0] peer_val,
   input  wire logic                 press,
   output logic                      peer_rts
);
   timeunit 1ns;
   timeprecision 100ps;
   // Driven lines read back, released ones show the peer
   assign line_in = (line_out & ~line_oe_n) | (peer_val & line_oe_n);
   // Button idles high through its pull-up
   assign factory_reset_button = !press;
   // Released handshake line floats to its pull-up
   assign peer_rts = line_oe_n[LINE_RTS] ? 1'b1 : line_out[LINE_RTS];
endmodule // pin_peer
`default_nettype wire

// ===== gpio_pin_function_tb_top.sv
/*
 * Self-checking bench for the pin function block over APB.
 * Assumes shortened timing parameters and the pin_peer model.
 */
`default_nettype none
module gpio_pin_function_tb_top
   import gpio_cfg_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int DB = 3;
   localparam int LP = 50;
   logic                 clk = 1'b0, nrst, psel, penable, pwrite;
   logic                 pready, pslverr, e, press, peer_rts;
   logic                 factory_reset_button, factory_restore, boot_menu;
   logic                 wake_req, join_open, uart_rts, uart_dtr;
   logic                 uart_cts, uart_dsr;
   logic [11:0]          paddr;
   logic [31:0]          pwdata, prdata, r;
   logic [NUM_LINES-1:0] line_in, line_out, line_oe_n, peer_val;
   logic [3:0]           analog_enable;
   int                   err_count = 0, compares = 0, cycles = 0;
   int                   wake_cnt = 0, rest_cnt = 0, ones;

   always #12.5 clk = ~clk;

   gpio_pin_function #(.LONG_PRESS(LP), .DEBOUNCE(DB), .BLINK(8),
      .SECOND(10)) u_dut (.clk(clk), .nrst(nrst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .line_in(line_in), .line_out(line_out), .line_oe_n(line_oe_n),
      .analog_enable(analog_enable),
      .factory_reset_button(factory_reset_button),
      .factory_restore(factory_restore), .boot_menu(boot_menu),
      .wake_req(wake_req), .join_open(join_open), .uart_rts(uart_rts),
      .uart_dtr(uart_dtr), .uart_cts(uart_cts), .uart_dsr(uart_dsr));

   pin_peer u_peer (.line_out(line_out), .line_oe_n(line_oe_n),
      .line_in(line_in), .factory_reset_button(factory_reset_button),
      .peer_val(peer_val), .press(press), .peer_rts(peer_rts));

   // ---------------------------------------------
   // Event counters and watchdog
   // ---------------------------------------------
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (wake_req === 1'b1) wake_cnt <= wake_cnt + 1;
      if (factory_restore === 1'b1) rest_cnt <= rest_cnt + 1;
      if (cycles == 20000) begin
         err_count++;
         print_verdict();
      end
   end

   task print_verdict;
      $display("compares=%0d err_count=%0d", compares, err_count);
      if (err_count == 0 && compares > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask

   task chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         err_count++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task settle;
      repeat (4) @(posedge clk);
      @(negedge clk);
   endtask

   task one(input int ln, input int m);
      apb(1'b1, OFS_MODE_ONE, 32'(ln * 16 + m));
      settle();
   endtask

   task count_hi(input int n, input int b);
      ones = 0;
      @(posedge clk);
      repeat (n) begin
         @(negedge clk);
         if (line_out[b] === 1'b1) ones++;
      end
   endtask

   task tap(input logic btn, input int n);
      @(posedge clk);
      if (btn) press <= 1'b1;
      else peer_val[0] <= 1'b0;
      repeat (n) @(posedge clk);
      press <= 1'b0;
      peer_val[0] <= 1'b1;
      repeat (DB + 8) @(posedge clk);
      @(negedge clk);
   endtask

   // ---------------------------------------------
   // Main sequence
   // ---------------------------------------------
   initial begin
      {nrst, psel, penable, pwrite, press, uart_rts, uart_dtr} = '0;
      paddr = '0;
      pwdata = '0;
      peer_val = '1;
      repeat (12) @(posedge clk);
      nrst <= 1'b1;
      repeat (DB + 10) @(posedge clk);
      apb(1'b0, OFS_JOIN_TIME, '0);
      chk(r, 32'h0000_00FF);
      apb(1'b0, 12'h020, '0);
      chk(e, 1'b1);
      chk(boot_menu, 1'b0);
      for (int m = 0; m < 4; m++) begin
         one(12, m);
         chk(line_oe_n[12], m < 2);
         if (m >= 2) chk(line_out[12], m[0]);
      end
      one(12, 4);
      chk({analog_enable, line_out[12]}, 32'h0000_0001);
      one(12, 6);
      chk({line_oe_n[12], line_out[12]}, 32'h0000_0001);
      for (int c = 0; c < 4; c++) begin
         one(3 + c, 4);
         chk({analog_enable[c], line_oe_n[3+c]}, 32'h0000_0003);
      end
      apb(1'b1, OFS_MODE_ALL, 32'h0000_0003);
      settle();
      chk({line_oe_n, line_out}, 32'h0000_1FFF);
      chk(analog_enable, 4'h0);
      apb(1'b0, OFS_MODE_ALL, '0);
      chk(r, 32'h1B6D_B6DB);
      apb(1'b1, OFS_MODE_ALL, 32'h0000_0004);
      settle();
      chk({analog_enable, line_out}, 32'h0001_FFFF);
      apb(1'b1, OFS_OUT, 32'h0000_1555);
      settle();
      chk(line_out, 13'h1555);
      apb(1'b1, OFS_MODE_ALL, 32'h0000_0001);
      @(posedge clk);
      peer_val <= 13'h0A5A;
      settle();
      apb(1'b0, OFS_IN, '0);
      chk(r, 32'h0000_0A5A);
      @(posedge clk);
      peer_val <= '1;
      for (int i = LINE_CTS; i <= LINE_DSR; i++) one(i, 5);
      for (int v = 0; v < 2; v++) begin
         @(posedge clk);
         uart_rts <= v[0];
         uart_dtr <= !v[0];
         peer_val[LINE_CTS] <= v[0];
         peer_val[LINE_DSR] <= !v[0];
         settle();
         chk({peer_rts, line_out[LINE_DTR]}, 32'(2 * v + 1 - v));
         chk({uart_dsr, uart_cts}, 32'(2 - v - v + v));
         apb(1'b0, OFS_UART, '0);
         chk(r, 32'(2 - v));
      end
      one(1, 5);
      apb(1'b1, OFS_NODE, 32'(NODE_COORD));
      count_hi(32, LINE_PWR);
      chk(ones, 32);
      apb(1'b1, OFS_NODE, 32'(NODE_END));
      count_hi(32, LINE_PWR);
      chk(ones, 16);
      one(2, 5);
      apb(1'b1, OFS_NODE, 32'h0000_0004);
      settle();
      chk(line_out[LINE_LINK], 1'b1);
      apb(1'b1, OFS_NODE, 32'(NODE_ROUTER));
      apb(1'b1, OFS_JOIN_TIME, 32'h0000_0005);
      settle();
      chk(line_out[LINE_LINK], 1'b0);
      tap(1'b0, DB + 6);
      chk(join_open, 1'b0);
      one(0, 5);
      tap(1'b0, DB + 6);
      chk(join_open, 1'b1);
      count_hi(16, LINE_LINK);
      chk(ones, 8);
      repeat (40) @(negedge clk);
      chk(join_open, 1'b0);
      apb(1'b1, OFS_NODE, 32'(NODE_SLEEPY));
      tap(1'b0, 1);
      chk(wake_cnt, 0);
      tap(1'b0, DB + 6);
      chk(wake_cnt, 1);
      apb(1'b0, OFS_STATUS, '0);
      chk(r & 32'h0000_0004, 32'h0000_0004);
      apb(1'b0, OFS_STATUS, '0);
      chk(r & 32'h0000_0004, 32'h0000_0000);
      tap(1'b1, 20);
      chk(rest_cnt, 0);
      tap(1'b1, LP + DB + 20);
      chk(rest_cnt, 1);
      @(posedge clk);
      press <= 1'b1;
      nrst <= 1'b0;
      repeat (12) @(posedge clk);
      nrst <= 1'b1;
      repeat (DB + 12) @(posedge clk);
      @(negedge clk);
      chk(boot_menu, 1'b1);
      apb(1'b0, OFS_STATUS, '0);
      chk(r & 32'h0000_0002, 32'h0000_0002);
      print_verdict();
   end
endmodule // gpio_pin_function_tb_top
`default_nettype wire
